// ===== sysrc_defs.vh
/*
 * Constants for the system reset controller: register byte offsets, field
 * positions, reset values and timing counts.
 * Assumes a 25 MHz clk_sys and that the including file defines nothing of the same name.
 */
`ifndef SYSRC_DEFS_VH
`define SYSRC_DEFS_VH

// ************************************************************
// register byte offsets (word aligned)
// ************************************************************
`define SYSRC_OFS_CAUSE 8'h00
`define SYSRC_OFS_BORCTL 8'h04
`define SYSRC_OFS_REGCTL 8'h08
`define SYSRC_OFS_SRST0 8'h0C
`define SYSRC_OFS_SRST1 8'h10
`define SYSRC_OFS_SRST2 8'h14
`define SYSRC_OFS_WDLOAD 8'h18
`define SYSRC_OFS_WDCTL 8'h1C
`define SYSRC_OFS_WDVAL 8'h20
`define SYSRC_OFS_STATUS 8'h24

// ************************************************************
// cause bits
// ************************************************************
`define SYSRC_CAUSE_EXT 0
`define SYSRC_CAUSE_POR 1
`define SYSRC_CAUSE_BOR 2
`define SYSRC_CAUSE_SW 3
`define SYSRC_CAUSE_WDT 4
`define SYSRC_CAUSE_LDO 5

// ************************************************************
// control fields
// ************************************************************
`define SYSRC_BOR_WAIT_BIT 0
`define SYSRC_BOR_EN_BIT 1
`define SYSRC_BOR_TIM_LSB 8
`define SYSRC_BOR_TIM_MSB 15
`define SYSRC_REG_REGULATOR_VOLTAGE_ADJUST_MSB 3
`define SYSRC_REG_RSTEN_BIT 8
`define SYSRC_WD_RUN_BIT 0
`define SYSRC_WD_RSTEN_BIT 1
`define SYSRC_ST_BOR_BIT 0
`define SYSRC_ST_WDI_BIT 1

// ************************************************************
// reset values
// ************************************************************
`define SYSRC_BORCTL_RST 32'h0000_0000
`define SYSRC_REGULATOR_VOLTAGE_ADJUST_RST 4'h5
`define SYSRC_REGULATOR_VOLTAGE_ADJUST_MAX 4'hA
`define SYSRC_WDLOAD_RST 32'hFFFF_FFFF

// ************************************************************
// timing
// ************************************************************
`define SYSRC_CLK_KHZ 25000
`define SYSRC_CLK_MHZ 25
`define SYSRC_SETTLE_MS 15
`define SYSRC_SETTLE_CYCLES (`SYSRC_SETTLE_MS * `SYSRC_CLK_KHZ)
`define SYSRC_IOSC_DIV 2
`define SYSRC_BOR_HOLD_US 500
`define SYSRC_BOR_HOLD_TICKS (`SYSRC_BOR_HOLD_US * `SYSRC_CLK_MHZ / `SYSRC_IOSC_DIV)
`define SYSRC_INT_HOLD_TICKS 16
`define SYSRC_SRST_CYCLES 8

`endif

// ===== sysrc_wdog.v
/*
 * Watchdog timer: 32-bit down-counter, interrupt on first time-out,
 * reset request on second time-out while the interrupt is still pending.
 * Assumes all inputs are synchronous to clk_sys.
 */
`timescale 1ns/1ns
`include "sysrc_defs.vh"
module sysrc_wdog (
  input wire clk_sys,
  input wire nrst,
  input wire clr,
  input wire run,
  input wire rst_en,
  input wire [31:0] load_val,
  input wire load_wr,
  input wire int_clr,
  output reg [31:0] count,
  output reg int_flag,
  output reg rst_req
);

  wire expire = run && (count == 32'h0000_0000);

  // ************************************************************
  // counter, interrupt and reset request
  // ************************************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= `SYSRC_WDLOAD_RST;
      int_flag <= 1'b0;
      rst_req <= 1'b0;
    end else if (clr) begin
      count <= `SYSRC_WDLOAD_RST;
      int_flag <= 1'b0;
      rst_req <= 1'b0;
    end else begin
      rst_req <= 1'b0;
      if (load_wr || expire) begin
        count <= load_val;
      end else if (run) begin
        count <= count - 32'h0000_0001;
      end
      // a time-out in the clearing cycle sets the flag only if it was clear; a pending flag is still cleared
      if (expire && !int_flag) begin
        int_flag <= 1'b1;
      end else if (int_clr) begin
        int_flag <= 1'b0;
      end
      if (expire && int_flag && rst_en) begin
        rst_req <= 1'b1;
      end
    end
  end

endmodule

// ===== sysrc_top.v
/*
 * System reset controller: collects six reset sources, sequences the
 * internal reset, records the cause, filters brown-out, drives peripheral
 * software resets and hosts the watchdog. Avalon-MM slave with waitrequest.
 * Assumes detector and pin inputs are asynchronous to clk_sys, and that the
 * core and the bus master run on clk_sys.
 */
`timescale 1ns/1ns
`include "sysrc_defs.vh"

// Function
// - six reset sources: pin, power-on, brown-out, software, watchdog, regulator.
// - each reset sets its cause bit; bits stay until software clears them.
// - external pin cause clears every other cause bit.
// - pin reset resets core and peripherals, not the test access port.
// - after pin release hold internal reset for 15-30 ms settling count.
// - at power-up wait for pin and power-on pulse inactive, then settle.
// - on release core fetches stack pointer, program counter, instruction, runs.
// - power-on reset only on initial power-up, never later.
// - brown-out resets only if enable bit set, else raises an interrupt.
// - brown-out reset disabled after power-up until software enables it.
// - with wait bit, resample brown-out after timing field delay; drop if gone.
// - after brown-out reset hold internal brown-out signal 500 us.
// - writing 1 to a bit of three soft reset registers resets that peripheral.
// - soft reset bit mapping matches the clock gating bit mapping.
// - a peripheral soft reset asserts resets of all its clock domains.
// - core system reset request resets the whole system including core.
// - watchdog reloads and interrupts first, resets on second time-out if enabled.
// - unregulated regulator with reset enabled sets its flag and resets.
// - voltage adjust field selects 2.25 V to 2.75 V in 50 mV steps.
// - pin and power-on timed by main clock, others by internal clock.
module sysrc_top #(
  parameter SETTLE_CYCLES = `SYSRC_SETTLE_CYCLES,
  parameter BOR_HOLD_TICKS = `SYSRC_BOR_HOLD_TICKS
) (
  input wire clk_sys,
  input wire nrst,
  input wire ext_rst_pin_n,
  input wire por_detect,
  input wire bor_detect,
  input wire ldo_unregulated,
  input wire system_reset_request,
  input wire core_fetch_done,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg core_rst_n,
  output reg periph_rst_n,
  output reg tap_rst_n,
  output reg [1:0] core_boot_phase,
  output reg [95:0] periph_soft_rst,
  output reg [3:0] regulator_voltage_adjust,
  output reg brownout_irq,
  output reg watchdog_irq
);

  localparam ST_WAIT = 3'd0;
  localparam ST_SETTLE = 3'd1;
  localparam ST_HOLD = 3'd2;
  localparam ST_SP = 3'd3;
  localparam ST_PC = 3'd4;
  localparam ST_INSN = 3'd5;
  localparam ST_RUN = 3'd6;

  localparam BOR_IDLE = 2'd0;
  localparam BOR_WAIT = 2'd1;
  localparam BOR_HOLD = 2'd2;

  localparam integer SETTLE_M1 = SETTLE_CYCLES - 1;
  localparam integer INT_HOLD_M1 = `SYSRC_INT_HOLD_TICKS - 1;
  localparam integer BOR_HOLD_M1 = BOR_HOLD_TICKS - 1;
  localparam integer SRST_M1 = `SYSRC_SRST_CYCLES - 1;
  localparam [19:0] SETTLE_LAST = SETTLE_M1[19:0];
  localparam [19:0] INT_HOLD_LAST = INT_HOLD_M1[19:0];
  localparam [15:0] BOR_HOLD_LAST = BOR_HOLD_M1[15:0];
  localparam [3:0] SRST_LAST = SRST_M1[3:0];

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          be_merge[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
    end
  endfunction

  function [3:0] regulator_voltage_adjust_clip;
    input [3:0] code;
    begin
      regulator_voltage_adjust_clip = (code > `SYSRC_REGULATOR_VOLTAGE_ADJUST_MAX) ? `SYSRC_REGULATOR_VOLTAGE_ADJUST_MAX : code;
    end
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [3:0] sync1;
  reg [3:0] sync2;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // power-on counts as active until the detector is really seen low
      sync1 <= 4'h3;
      sync2 <= 4'h3;
    end else begin
      sync1 <= {ldo_unregulated, bor_detect, por_detect, ext_rst_pin_n};
      sync2 <= sync1;
    end
  end
  wire ext_n_s = sync2[0];
  wire por_s = sync2[1];
  wire bor_s = sync2[2];
  wire ldo_s = sync2[3];

  // ************************************************************
  // internal oscillator timebase
  // ************************************************************
  reg iosc_div;
  wire iosc_tick = iosc_div;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      iosc_div <= 1'b0;
    end else begin
      iosc_div <= ~iosc_div;
    end
  end

  // ************************************************************
  // bus slave: one wait cycle, then answer
  // ************************************************************
  wire bus_req = avs_read || avs_write;
  wire wr_fire = avs_write && !avs_waitrequest;
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] w1 = avs_writedata & wmask;

  reg [5:0] cause;
  reg [31:0] borctl;
  reg ldo_rst_en;
  reg [31:0] wd_load;
  reg wd_run;
  reg wd_rsten;
  reg bor_flag;
  reg [2:0] state;
  wire [95:0] srst_pend;
  wire [31:0] wd_count;
  wire wd_int;
  wire wd_rst;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `SYSRC_OFS_CAUSE: rd_mux = {26'h000_0000, cause};
      `SYSRC_OFS_BORCTL: rd_mux = borctl;
      `SYSRC_OFS_REGCTL: rd_mux = {23'h00_0000, ldo_rst_en, 4'h0, regulator_voltage_adjust};
      `SYSRC_OFS_SRST0: rd_mux = srst_pend[31:0];
      `SYSRC_OFS_SRST1: rd_mux = srst_pend[63:32];
      `SYSRC_OFS_SRST2: rd_mux = srst_pend[95:64];
      `SYSRC_OFS_WDLOAD: rd_mux = wd_load;
      `SYSRC_OFS_WDCTL: rd_mux = {30'h0000_0000, wd_rsten, wd_run};
      `SYSRC_OFS_WDVAL: rd_mux = wd_count;
      `SYSRC_OFS_STATUS: rd_mux = {30'h0000_0000, wd_int, bor_flag};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  wire wr_cause = wr_fire && (avs_address == `SYSRC_OFS_CAUSE);
  wire wr_borctl = wr_fire && (avs_address == `SYSRC_OFS_BORCTL);
  wire wr_regctl = wr_fire && (avs_address == `SYSRC_OFS_REGCTL);
  wire wr_wdload = wr_fire && (avs_address == `SYSRC_OFS_WDLOAD);
  wire wr_wdctl = wr_fire && (avs_address == `SYSRC_OFS_WDCTL);
  wire wr_status = wr_fire && (avs_address == `SYSRC_OFS_STATUS);

  // ************************************************************
  // reset sources
  // ************************************************************
  reg por_done;
  reg bor_fire;
  wire src_ext = !ext_n_s;
  wire src_por = por_s && !por_done;
  wire src_ldo = ldo_s && ldo_rst_en;
  wire src_main = src_ext || src_por;
  wire src_int = bor_fire || system_reset_request || wd_rst || src_ldo;
  wire in_reset = (state == ST_WAIT) || (state == ST_SETTLE) || (state == ST_HOLD);

  // ************************************************************
  // reset sequencer
  // ************************************************************
  reg [2:0] next_state;
  reg [19:0] next_cnt;
  reg [19:0] cnt;
  always @* begin
    next_state = state;
    next_cnt = cnt;
    if (src_main) begin
      next_state = ST_WAIT;
      next_cnt = 20'h0_0000;
    end else if (src_int) begin
      next_state = ST_HOLD;
      next_cnt = 20'h0_0000;
    end else begin
      case (state)
        ST_WAIT: begin
          next_state = ST_SETTLE;
          next_cnt = 20'h0_0000;
        end
        ST_SETTLE: begin
          // main clock paces the settling count
          if (cnt == SETTLE_LAST) begin
            next_state = ST_SP;
          end else begin
            next_cnt = cnt + 20'h0_0001;
          end
        end
        ST_HOLD: begin
          if (iosc_tick) begin
            if (cnt == INT_HOLD_LAST) begin
              next_state = ST_SP;
            end else begin
              next_cnt = cnt + 20'h0_0001;
            end
          end
        end
        ST_SP: if (core_fetch_done) next_state = ST_PC;
        ST_PC: if (core_fetch_done) next_state = ST_INSN;
        ST_INSN: if (core_fetch_done) next_state = ST_RUN;
        ST_RUN: next_state = ST_RUN;
        default: next_state = ST_WAIT;
      endcase
    end
  end

  wire next_in_reset = (next_state == ST_WAIT) || (next_state == ST_SETTLE) ||
                       (next_state == ST_HOLD);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_WAIT;
      cnt <= 20'h0_0000;
      por_done <= 1'b0;
      core_rst_n <= 1'b0;
      periph_rst_n <= 1'b0;
      tap_rst_n <= 1'b0;
      core_boot_phase <= 2'd0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (state == ST_SETTLE) begin
        por_done <= 1'b1;
      end
      core_rst_n <= !next_in_reset;
      periph_rst_n <= !next_in_reset;
      // test access port only follows the power-on pulse
      tap_rst_n <= !(next_state == ST_WAIT && !por_done);
      case (next_state)
        ST_SP: core_boot_phase <= 2'd1;
        ST_PC: core_boot_phase <= 2'd2;
        ST_INSN: core_boot_phase <= 2'd3;
        default: core_boot_phase <= 2'd0;
      endcase
    end
  end

  // ************************************************************
  // cause register, write 1 to clear, set wins
  // ************************************************************
  wire [5:0] cause_set = {src_ldo, wd_rst, system_reset_request, bor_fire,
                          src_por, src_ext};
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cause <= 6'h00;
    end else if (src_ext) begin
      cause <= 6'h01 << `SYSRC_CAUSE_EXT;
    end else begin
      cause <= (cause & ~(wr_cause ? w1[5:0] : 6'h00)) | cause_set;
    end
  end

  // ************************************************************
  // control registers, restored to reset values by every internal reset
  // ************************************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      borctl <= `SYSRC_BORCTL_RST;
      ldo_rst_en <= 1'b0;
      regulator_voltage_adjust <= `SYSRC_REGULATOR_VOLTAGE_ADJUST_RST;
      wd_load <= `SYSRC_WDLOAD_RST;
      wd_run <= 1'b0;
      wd_rsten <= 1'b0;
    end else if (in_reset) begin
      borctl <= `SYSRC_BORCTL_RST;
      ldo_rst_en <= 1'b0;
      regulator_voltage_adjust <= `SYSRC_REGULATOR_VOLTAGE_ADJUST_RST;
      wd_load <= `SYSRC_WDLOAD_RST;
      wd_run <= 1'b0;
      wd_rsten <= 1'b0;
    end else begin
      if (wr_borctl) begin
        borctl <= be_merge(borctl, avs_writedata, avs_byteenable) & 32'h0000_FF03;
      end
      if (wr_regctl) begin
        if (avs_byteenable[0]) begin
          regulator_voltage_adjust <= regulator_voltage_adjust_clip(avs_writedata[`SYSRC_REG_REGULATOR_VOLTAGE_ADJUST_MSB:0]);
        end
        if (avs_byteenable[1]) begin
          ldo_rst_en <= avs_writedata[`SYSRC_REG_RSTEN_BIT];
        end
      end
      if (wr_wdload) begin
        wd_load <= be_merge(wd_load, avs_writedata, avs_byteenable);
      end
      if (wr_wdctl && avs_byteenable[0]) begin
        wd_run <= avs_writedata[`SYSRC_WD_RUN_BIT];
        wd_rsten <= avs_writedata[`SYSRC_WD_RSTEN_BIT];
      end
    end
  end

  // ************************************************************
  // brown-out filter and hold
  // ************************************************************
  reg [1:0] bor_st;
  reg [15:0] bcnt;
  wire [15:0] resample_last = {4'h0, borctl[`SYSRC_BOR_TIM_MSB:`SYSRC_BOR_TIM_LSB], 4'hF};
  reg bor_confirm;
  always @* begin
    bor_confirm = 1'b0;
    if (bor_st == BOR_IDLE && bor_s && !borctl[`SYSRC_BOR_WAIT_BIT]) begin
      bor_confirm = 1'b1;
    end else if (bor_st == BOR_WAIT && iosc_tick && bcnt == resample_last) begin
      bor_confirm = bor_s;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bor_st <= BOR_IDLE;
      bcnt <= 16'h0000;
      bor_fire <= 1'b0;
      bor_flag <= 1'b0;
    end else begin
      bor_fire <= 1'b0;
      if (bor_confirm && !borctl[`SYSRC_BOR_EN_BIT]) begin
        bor_flag <= 1'b1;
      end else if (wr_status && w1[`SYSRC_ST_BOR_BIT]) begin
        bor_flag <= 1'b0;
      end
      case (bor_st)
        BOR_IDLE: begin
          bcnt <= 16'h0000;
          if (bor_s && borctl[`SYSRC_BOR_WAIT_BIT]) begin
            bor_st <= BOR_WAIT;
          end else if (bor_confirm && borctl[`SYSRC_BOR_EN_BIT]) begin
            bor_fire <= 1'b1;
            bor_st <= BOR_HOLD;
          end
        end
        BOR_WAIT: begin
          if (iosc_tick) begin
            if (bcnt == resample_last) begin
              bcnt <= 16'h0000;
              if (bor_confirm && borctl[`SYSRC_BOR_EN_BIT]) begin
                bor_fire <= 1'b1;
                bor_st <= BOR_HOLD;
              end else begin
                bor_st <= BOR_IDLE;
              end
            end else begin
              bcnt <= bcnt + 16'h0001;
            end
          end
        end
        BOR_HOLD: begin
          // detector ignored so software can inspect the first event
          if (iosc_tick) begin
            if (bcnt == BOR_HOLD_LAST) begin
              bor_st <= BOR_IDLE;
            end else begin
              bcnt <= bcnt + 16'h0001;
            end
          end
        end
        default: bor_st <= BOR_IDLE;
      endcase
    end
  end

  // ************************************************************
  // peripheral software resets, bit n = clock gating bit n
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : srst
      reg [3:0] hold;
      reg [31:0] pend;
      wire wr_hit = wr_fire && (avs_address == (`SYSRC_OFS_SRST0 + 8'h04 * g));
      assign srst_pend[g*32 +: 32] = pend;
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          pend <= 32'h0000_0000;
          hold <= 4'h0;
        end else if (wr_hit) begin
          pend <= pend | w1;
          hold <= SRST_LAST;
        end else if (hold != 4'h0) begin
          hold <= hold - 4'h1;
        end else begin
          pend <= 32'h0000_0000;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      periph_soft_rst <= {96{1'b1}};
    end else begin
      // one bit fans out to every clock domain of its unit
      periph_soft_rst <= srst_pend | {96{next_in_reset}};
    end
  end

  // ************************************************************
  // watchdog
  // ************************************************************
  sysrc_wdog i_sysrc_wdog (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clr(in_reset),
    .run(wd_run),
    .rst_en(wd_rsten),
    // a load write reloads with the value being written, not the old one
    .load_val(wr_wdload ? be_merge(wd_load, avs_writedata, avs_byteenable) : wd_load),
    .load_wr(wr_wdload),
    .int_clr(wr_status && w1[`SYSRC_ST_WDI_BIT]),
    .count(wd_count),
    .int_flag(wd_int),
    .rst_req(wd_rst)
  );

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brownout_irq <= 1'b0;
      watchdog_irq <= 1'b0;
    end else begin
      brownout_irq <= bor_flag;
      watchdog_irq <= wd_int;
    end
  end

endmodule

// ===== sysrc_top_assertions.sv
/* port checker for sysrc_top.
   assumes one clk_sys domain and SETTLE_CYCLES as set on the instance. */
`timescale 1ns/1ns
// ****
// checker
// ****
module sysrc_chk #(
  parameter SETTLE_CYCLES = 20
) (
  input wire clk_sys,
  input wire nrst,
  input wire ext_rst_pin_n,
  input wire system_reset_request,
  input wire core_fetch_done,
  input wire core_rst_n,
  input wire periph_rst_n,
  input wire tap_rst_n,
  input wire [1:0] core_boot_phase,
  input wire [95:0] periph_soft_rst,
  input wire [3:0] regulator_voltage_adjust
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_tap; !tap_rst_n |-> !core_rst_n && !periph_rst_n; endproperty
  a_tap: assert property (p_tap) else $error("tap reset outside core reset");
  // one cycle of slack for the registered fan-out
  property p_all; !core_rst_n && $past(!core_rst_n) |-> &periph_soft_rst; endproperty
  a_all: assert property (p_all) else $error("unit resets not all set");
  property p_pin; (!ext_rst_pin_n) [*5] |-> !core_rst_n; endproperty
  a_pin: assert property (p_pin) else $error("pin low but core runs");
  property p_settle; $rose(core_rst_n) |-> $past(ext_rst_pin_n, SETTLE_CYCLES); endproperty
  a_settle: assert property (p_settle) else $error("release before settling");
  property p_boot; $rose(core_rst_n) |-> ##[0:2] core_boot_phase == 2'd1; endproperty
  a_boot: assert property (p_boot) else $error("boot did not start with stack fetch");
  property p_seq;
    core_fetch_done && core_boot_phase != 2'd0 |=>
      core_boot_phase == $past(core_boot_phase) + 2'd1;
  endproperty
  a_seq: assert property (p_seq) else $error("boot fetch order wrong");
  property p_srq; system_reset_request |-> ##[1:3] !core_rst_n; endproperty
  a_srq: assert property (p_srq) else $error("system request ignored");
  property p_hold; $fell(core_rst_n) |=> !core_rst_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  property p_regulator_voltage_adjust; regulator_voltage_adjust <= 4'hA; endproperty
  a_regulator_voltage_adjust: assert property (p_regulator_voltage_adjust) else $error("voltage code above 2.75 V");
endmodule
bind sysrc_top sysrc_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_sysrc_chk (.clk_sys, .nrst,
  .ext_rst_pin_n, .system_reset_request, .core_fetch_done, .core_rst_n, .periph_rst_n,
  .tap_rst_n, .core_boot_phase, .periph_soft_rst, .regulator_voltage_adjust);

// ===== sysrc_core_model.sv
/* boot side of the core: answers each fetch phase with one done pulse.
   assumes the phase moves one cycle after the pulse; delay must be >= 1. */
`timescale 1ns/1ns
module sysrc_core_model (
  input wire clk_sys,
  input wire nrst,
  input wire [1:0] core_boot_phase,
  input wire [3:0] delay,
  output reg core_fetch_done
);
  reg [3:0] cnt;
  reg [1:0] last;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      last <= 2'd0;
      core_fetch_done <= 1'b0;
    end else begin
      last <= core_boot_phase;
      core_fetch_done <= 1'b0;
      // restart on every phase change so one fetch gets one pulse
      if (core_boot_phase == 2'd0 || core_boot_phase != last) begin
        cnt <= 4'h0;
      end else if (cnt == delay) begin
        core_fetch_done <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ===== system_reset_controller_bench.sv
/* bench for sysrc_top with the core model.
   assumes short settle and hold counts set on the instance. */
`timescale 1ns/1ns
module system_reset_controller_bench;
  localparam SETTLE = 20;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg ext_rst_pin_n = 1'b1;
  reg por_detect = 1'b1;
  reg bor_detect = 1'b0;
  reg ldo_unregulated = 1'b0;
  reg system_reset_request = 1'b0;
  reg [7:0] avs_address = 8'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hF;
  reg [3:0] dly = 4'h2;
  wire core_fetch_done, avs_waitrequest, core_rst_n, periph_rst_n, tap_rst_n;
  wire brownout_irq, watchdog_irq;
  wire [31:0] avs_readdata;
  wire [1:0] core_boot_phase;
  wire [95:0] periph_soft_rst;
  wire [3:0] regulator_voltage_adjust;
  integer n_errors = 0;
  integer compares = 0;
  integer i;
  integer cyc;
  reg [31:0] rv;
  sysrc_top #(.SETTLE_CYCLES(SETTLE), .BOR_HOLD_TICKS(10)) i_sysrc_top (.clk_sys, .nrst,
    .ext_rst_pin_n, .por_detect, .bor_detect, .ldo_unregulated, .system_reset_request,
    .core_fetch_done, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .core_rst_n, .periph_rst_n, .tap_rst_n,
    .core_boot_phase, .periph_soft_rst, .regulator_voltage_adjust, .brownout_irq,
    .watchdog_irq);
  sysrc_core_model i_sysrc_core_model (.clk_sys, .nrst, .core_boot_phase, .delay(dly),
    .core_fetch_done);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task conclude;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task hang;
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t wait ran out", $time);
      conclude;
    end
  endtask
  // leading edge keeps a release and the next request apart
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
        n = n + 1;
        if (n > 50) hang;
        @(posedge clk_sys);
      end
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(rv, exp);
    end
  endtask
  task wt(input v, input integer lim);
    begin
      cyc = 0;
      while (core_rst_n !== v) begin
        cyc = cyc + 1;
        if (cyc > lim) hang;
        @(posedge clk_sys);
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(tap_rst_n, 1'b0);
    por_detect <= 1'b0;
    wt(1'b1, 60);
    chk(tap_rst_n, 1'b1);
    repeat (30) @(posedge clk_sys);
    chk(core_boot_phase, 2'd0);
    rdc(8'h00, 32'h2);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h5);
    rdc(8'h40, 32'h0);
    bus(1'b1, 8'h00, 32'h3F);
    rdc(8'h00, 32'h0);
    por_detect <= 1'b1;
    bor_detect <= 1'b1;
    repeat (10) @(posedge clk_sys);
    por_detect <= 1'b0;
    bor_detect <= 1'b0;
    chk(core_rst_n, 1'b1);
    chk(brownout_irq, 1'b1);
    rdc(8'h24, 32'h1);
    bus(1'b1, 8'h24, 32'h1);
    rdc(8'h24, 32'h0);
    dly <= 4'h9;
    system_reset_request <= 1'b1;
    @(posedge clk_sys);
    system_reset_request <= 1'b0;
    wt(1'b0, 5);
    wt(1'b1, 100);
    repeat (50) @(posedge clk_sys);
    dly <= 4'h2;
    rdc(8'h00, 32'h8);
    bus(1'b1, 8'h04, 32'h2);
    bor_detect <= 1'b1;
    wt(1'b0, 10);
    bor_detect <= 1'b0;
    wt(1'b1, 200);
    rdc(8'h00, 32'hC);
    // zero resample field: second look 32 cycles later
    bus(1'b1, 8'h04, 32'h3);
    bor_detect <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bor_detect <= 1'b0;
    repeat (80) @(posedge clk_sys);
    chk(core_rst_n, 1'b1);
    bor_detect <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk(core_rst_n, 1'b1);
    wt(1'b0, 40);
    bor_detect <= 1'b0;
    wt(1'b1, 200);
    ext_rst_pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({core_rst_n, periph_rst_n, tap_rst_n}, 3'b001);
    ext_rst_pin_n <= 1'b1;
    wt(1'b1, 60);
    chk(cyc >= SETTLE && cyc <= 2 * SETTLE, 1'b1);
    rdc(8'h00, 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1'b1, 8'h0C + i[7:0] * 8'h4, 32'h8000_0001);
      repeat (2) @(negedge clk_sys);
      chk(periph_soft_rst >> (32 * i), 32'h8000_0001);
    end
    rdc(8'h14, 32'h8000_0001);
    repeat (12) @(posedge clk_sys);
    chk({|periph_soft_rst, core_rst_n}, 2'b01);
    bus(1'b1, 8'h08, 32'hF);
    rdc(8'h08, 32'hA);
    bus(1'b1, 8'h08, 32'h103);
    rdc(8'h08, 32'h103);
    chk(regulator_voltage_adjust, 4'h3);
    ldo_unregulated <= 1'b1;
    wt(1'b0, 10);
    wt(1'b1, 200);
    ldo_unregulated <= 1'b0;
    rdc(8'h00, 32'h21);
    rdc(8'h08, 32'h5);
    bus(1'b1, 8'h18, 32'h28);
    bus(1'b1, 8'h1C, 32'h3);
    i = 0;
    while (watchdog_irq !== 1'b1) begin
      i = i + 1;
      if (i > 100) hang;
      @(posedge clk_sys);
    end
    chk(core_rst_n, 1'b1);
    wt(1'b0, 100);
    wt(1'b1, 200);
    rdc(8'h00, 32'h31);
    conclude;
  end
endmodule
